// ---- src/iav_consts.vh ----
/*
 * constants for the inclination angle validity unit: apb offsets,
 * field positions, reset values and fixed-point scales.
 * assumes 16-bit signed acceleration samples, 1 g = IAV_ONE_G counts,
 * angles in 1/128 degree as 16-bit signed values.
 */
// Contract
// RULE_01 - error is abs of one g minus magnitude
// RULE_02 - error above maximum flags angles invalid
// RULE_03 - software supplies maximum allowed gravity error
// RULE_04 - roll undefined when gy and gz zero
// RULE_05 - unit pitch undefined when gx, gz zero
// RULE_06 - frame remap reorients axes used in formulas
// RULE_07 - only pitch and roll, never yaw
// RULE_08 - euler angles always computed internally
// RULE_09 - euler pitch within plus minus ninety
// RULE_10 - euler roll spans plus minus one eighty
// RULE_11 - wide tilt spans one eighty, jumps allowed
// RULE_12 - narrow tilt uses magnitude denominators, ninety
// RULE_13 - gravity angle above ninety means roll-over
// RULE_14 - setting selects one of four angle types
`ifndef IAV_CONSTS_VH
`define IAV_CONSTS_VH

// ==========================================================
// register byte addresses
`define IAV_A_CTRL    8'h00
`define IAV_A_FRAME   8'h04
`define IAV_A_MAXERR  8'h08
`define IAV_A_STATUS  8'h0c
`define IAV_A_ANGLES  8'h10
`define IAV_A_EULER   8'h14
`define IAV_A_GERR    8'h18
`define IAV_A_GANGLE  8'h1c
`define IAV_A_COUNT   8'h20

// ==========================================================
// reset values
`define IAV_CTRL_RST   2'h0
`define IAV_FRAME_RST  11'h210
`define IAV_MAXERR_RST 20'h00800

// ==========================================================
// angle types
`define IAV_T_TILT90  2'h0
`define IAV_T_TILT180 2'h1
`define IAV_T_UNIT    2'h2
`define IAV_T_EULER   2'h3

// ==========================================================
// status bit positions
`define IAV_S_INVALID 0
`define IAV_S_ROLLOVR 1
`define IAV_S_BUSY    2
`define IAV_S_HAVE    3

// ==========================================================
// scales
`define IAV_ONE_G   20'h04000
`define IAV_DEG90   16'h2d00
`define IAV_DEG180  17'h05a00
`define IAV_K_GAIN  16'h4dba

`endif

// ---- src/iav_cordic.v ----
/*
 * vectoring cordic: atan2(y, x) and sqrt(x*x + y*y), one step a clock.
 * assumes start is a one-cycle pulse while the unit is idle.
 */
`timescale 1ns/10ps
`include "iav_consts.vh"

module iav_cordic #(
    parameter W = 20,
    parameter N = 14
) (
    // clock and reset
    input  wire                pclk,
    input  wire                presetn,
    // request
    input  wire                start,
    input  wire signed [W-1:0] x_in,
    input  wire signed [W-1:0] y_in,
    // answer
    output reg                 done_q,
    output reg  signed [15:0]  ang_q,
    output reg  [W-1:0]        mag_q
);
    // ==========================================================
    // state
    reg signed [W+1:0]  x_q;     // grows by cordic gain
    reg signed [W+1:0]  y_q;
    reg signed [16:0]   z_q;     // wide enough for pre-rotation
    reg [3:0]           i_q;     // step index
    reg                 run_q;   // iterating
    wire signed [W+18:0] prod;   // gain-compensated magnitude, full product width

    // atan(2^-i) in 1/128 degree
    function [16:0] iav_atan;
        input [3:0] i;
        begin
            case (i)
                4'h0: iav_atan = 17'h01680;
                4'h1: iav_atan = 17'h00d48;
                4'h2: iav_atan = 17'h00705;
                4'h3: iav_atan = 17'h00390;
                4'h4: iav_atan = 17'h001ca;
                4'h5: iav_atan = 17'h000e5;
                4'h6: iav_atan = 17'h00073;
                4'h7: iav_atan = 17'h00039;
                4'h8: iav_atan = 17'h0001d;
                4'h9: iav_atan = 17'h0000e;
                4'ha: iav_atan = 17'h00007;
                4'hb: iav_atan = 17'h00004;
                4'hc: iav_atan = 17'h00002;
                default: iav_atan = 17'h00001;
            endcase
        end
    endfunction

    assign prod = x_q * $signed({1'b0, `IAV_K_GAIN});

    // ==========================================================
    // left half plane is folded by 180 degrees first so the
    // iteration always converges; result covers -180..+180
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_q    <= {(W+2){1'b0}};
            y_q    <= {(W+2){1'b0}};
            z_q    <= 17'h0;
            i_q    <= 4'h0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
            ang_q  <= 16'h0;
            mag_q  <= {W{1'b0}};
        end else begin
            done_q <= 1'b0;
            if (start) begin
                i_q   <= 4'h0;
                run_q <= 1'b1;
                if (x_in[W-1]) begin
                    // rotate by half a turn
                    x_q <= -{{2{x_in[W-1]}}, x_in};
                    y_q <= -{{2{y_in[W-1]}}, y_in};
                    z_q <= y_in[W-1] ? -`IAV_DEG180 : `IAV_DEG180;
                end else begin
                    x_q <= {{2{x_in[W-1]}}, x_in};
                    y_q <= {{2{y_in[W-1]}}, y_in};
                    z_q <= 17'h0;
                end
            end else if (run_q) begin
                if (!y_q[W+1]) begin
                    // drive y down toward zero
                    x_q <= x_q + (y_q >>> i_q);
                    y_q <= y_q - (x_q >>> i_q);
                    z_q <= z_q + $signed(iav_atan(i_q));
                end else begin
                    x_q <= x_q - (y_q >>> i_q);
                    y_q <= y_q + (x_q >>> i_q);
                    z_q <= z_q - $signed(iav_atan(i_q));
                end
                if (i_q == N[3:0] - 4'h1) begin
                    run_q <= 1'b0;
                end
                i_q <= i_q + 4'h1;
            end else if (i_q == N[3:0]) begin
                // one more cycle to finish with compensated values
                done_q <= 1'b1;
                ang_q  <= z_q[15:0];
                mag_q  <= prod[W+14:15];
                i_q    <= 4'h0;
            end
        end
    end
endmodule

// ---- src/iav_top.v ----
/*
 * inclination angle unit: pitch, roll, gravity angle and gravity
 * error from one three-axis sample, with an apb register slave.
 * assumes samples arrive synchronous to pclk, handshaken by
 * accel_valid and accel_ready.
 */
`timescale 1ns/10ps
`include "iav_consts.vh"

module iav_top #(
    parameter W = 20
) (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // accelerometer samples
    input  wire [15:0] accel_x,
    input  wire [15:0] accel_y,
    input  wire [15:0] accel_z,
    input  wire        accel_valid,
    output reg         accel_ready,
    // results
    output reg  [15:0] pitch_out,
    output reg  [15:0] roll_out,
    output reg         angle_invalid,
    output reg         roll_over,
    output reg         result_valid
);
    // ==========================================================
    // states
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_DONE = 2'h2;

    // ==========================================================
    // registers
    reg [1:0]          type_q;     // selected angle type
    reg [10:0]         frame_q;    // axis remap, 3 bits per axis
    reg [W-1:0]        maxerr_q;   // allowed gravity error
    reg [1:0]          st_q;       // sequencer state
    reg [2:0]          op_q;       // cordic job index
    reg                start_q;    // cordic start pulse
    reg [W-1:0]        gx_q;       // gravity components, remapped
    reg [W-1:0]        gy_q;
    reg [W-1:0]        gz_q;
    reg [15:0]         res_ang [0:7]; // per-job angle
    reg [W-1:0]        res_mag [0:7]; // per-job magnitude
    reg [15:0]         eul_p_q;    // euler pitch, always kept
    reg [15:0]         eul_r_q;    // euler roll, always kept
    reg [W-1:0]        gerr_q;     // gravity error
    reg [15:0]         rho_q;      // gravity angle
    reg                have_q;     // at least one result
    reg [15:0]         count_q;    // samples processed
    reg [W-1:0]        cx;         // cordic operands
    reg [W-1:0]        cy;
    reg [31:0]         rd_d;       // read data next
    reg                err_d;      // unmapped address
    reg [15:0]         pitch_d;    // type-selected angles
    reg [15:0]         roll_d;
    wire               c_done;
    wire [15:0]        c_ang;
    wire [W-1:0]       c_mag;
    wire [W:0]         gdiff;
    wire [W-1:0]       gerr_d;
    wire [W-1:0]       ax_g;
    wire [W-1:0]       ay_g;
    wire [W-1:0]       az_g;
    wire               wr_en;

    // ==========================================================
    // helpers
    function [W-1:0] iav_neg;
        input [W-1:0] v;
        begin
            iav_neg = ~v + {{(W-1){1'b0}}, 1'b1};
        end
    endfunction

    // pick a source axis and optional sign flip for one frame axis
    function [W-1:0] iav_pick;
        input [2:0]   cfg;
        input [W-1:0] ax;
        input [W-1:0] ay;
        input [W-1:0] az;
        reg   [W-1:0] v;
        begin
            if (cfg[1:0] == 2'h0) begin
                v = ax;
            end else if (cfg[1:0] == 2'h1) begin
                v = ay;
            end else begin
                v = az;
            end
            iav_pick = cfg[2] ? iav_neg(v) : v;
        end
    endfunction

    // gravity is the negated measured acceleration, sign-extended
    assign ax_g = iav_neg({{(W-16){accel_x[15]}}, accel_x});
    assign ay_g = iav_neg({{(W-16){accel_y[15]}}, accel_y});
    assign az_g = iav_neg({{(W-16){accel_z[15]}}, accel_z});

    // ==========================================================
    // cordic job operands; magnitudes of earlier jobs are reused
    // so the sequence order matters. zero vectors give whatever the
    // cordic leaves, which is acceptable at gimbal lock
    always @* begin
        case (op_q)
            3'h0: begin                            // RULE_04
                cx = gz_q;
                cy = gy_q;
            end
            3'h1: begin                            // RULE_05
                cx = gz_q;
                cy = iav_neg(gx_q);
            end
            3'h2: begin                            // RULE_09
                cx = res_mag[0];
                cy = iav_neg(gx_q);
            end
            3'h3: begin                            // RULE_12
                cx = res_mag[1];
                cy = gy_q;
            end
            3'h4: begin                            // RULE_11
                cx = gz_q[W-1] ? iav_neg(res_mag[0]) : res_mag[0];
                cy = iav_neg(gx_q);
            end
            3'h5: begin                            // RULE_11
                cx = gz_q[W-1] ? iav_neg(res_mag[1]) : res_mag[1];
                cy = gy_q;
            end
            3'h6: begin
                cx = gx_q;
                cy = gy_q;
            end
            default: begin                         // RULE_13
                cx = gz_q;
                cy = res_mag[6];
            end
        endcase
    end

    iav_cordic #(
        .W (W),
        .N (14)
    ) u_cordic (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start_q),
        .x_in    (cx),
        .y_in    (cy),
        .done_q  (c_done),
        .ang_q   (c_ang),
        .mag_q   (c_mag)
    );

    // ==========================================================
    // gravity error: job 2 magnitude is the full 3-axis length
    assign gdiff  = {1'b0, res_mag[2]} - {1'b0, `IAV_ONE_G};    // RULE_01
    assign gerr_d = gdiff[W] ? iav_neg(gdiff[W-1:0]) : gdiff[W-1:0]; // RULE_01

    // output angle pair by type; no yaw is ever produced
    always @* begin
        case (type_q)                                   // RULE_14
            `IAV_T_TILT90: begin                        // RULE_12
                pitch_d = res_ang[2];
                roll_d  = res_ang[3];
            end
            `IAV_T_TILT180: begin                       // RULE_11
                pitch_d = res_ang[4];
                roll_d  = res_ang[5];
            end
            `IAV_T_UNIT: begin
                pitch_d = res_ang[1];
                roll_d  = res_ang[0];
            end
            default: begin                              // RULE_10
                pitch_d = res_ang[2];
                roll_d  = res_ang[0];
            end
        endcase
    end

    // ==========================================================
    // sample sequencer: take, run eight cordic jobs, publish
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q          <= ST_IDLE;
            op_q          <= 3'h0;
            start_q       <= 1'b0;
            gx_q          <= {W{1'b0}};
            gy_q          <= {W{1'b0}};
            gz_q          <= {W{1'b0}};
            accel_ready   <= 1'b1;
            result_valid  <= 1'b0;
            pitch_out     <= 16'h0;
            roll_out      <= 16'h0;
            angle_invalid <= 1'b0;
            roll_over     <= 1'b0;
            eul_p_q       <= 16'h0;
            eul_r_q       <= 16'h0;
            gerr_q        <= {W{1'b0}};
            rho_q         <= 16'h0;
            have_q        <= 1'b0;
            count_q       <= 16'h0;
        end else begin
            start_q      <= 1'b0;
            result_valid <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (accel_valid) begin
                        // frame remap ahead of every formula
                        gx_q        <= iav_pick(frame_q[2:0], ax_g, ay_g, az_g);  // RULE_06
                        gy_q        <= iav_pick(frame_q[6:4], ax_g, ay_g, az_g);  // RULE_06
                        gz_q        <= iav_pick(frame_q[10:8], ax_g, ay_g, az_g); // RULE_06
                        op_q        <= 3'h0;
                        start_q     <= 1'b1;
                        accel_ready <= 1'b0;
                        st_q        <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (c_done) begin
                        if (op_q == 3'h7) begin
                            st_q <= ST_DONE;
                        end else begin
                            op_q    <= op_q + 3'h1;
                            start_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    pitch_out     <= pitch_d;                    // RULE_07
                    roll_out      <= roll_d;
                    eul_p_q       <= res_ang[2];                 // RULE_08
                    eul_r_q       <= res_ang[0];                 // RULE_08
                    gerr_q        <= gerr_d;
                    angle_invalid <= (gerr_d > maxerr_q);        // RULE_02
                    roll_over     <= ($signed(res_ang[7]) > $signed(`IAV_DEG90)); // RULE_13
                    rho_q         <= res_ang[7];
                    have_q        <= 1'b1;
                    count_q       <= count_q + 16'h1;
                    result_valid  <= 1'b1;
                    accel_ready   <= 1'b1;
                    st_q          <= ST_IDLE;
                end
            endcase
        end
    end

    // result memory, written as each job finishes
    always @(posedge pclk) begin
        if (c_done) begin
            res_ang[op_q] <= c_ang;
            res_mag[op_q] <= c_mag;
        end
    end

    // ==========================================================
    // apb read decode
    always @* begin
        rd_d  = 32'h0;
        err_d = 1'b0;
        if (paddr == `IAV_A_CTRL) begin
            rd_d[1:0] = type_q;
        end else if (paddr == `IAV_A_FRAME) begin
            rd_d[10:0] = frame_q;
        end else if (paddr == `IAV_A_MAXERR) begin
            rd_d[W-1:0] = maxerr_q;
        end else if (paddr == `IAV_A_STATUS) begin
            rd_d[`IAV_S_INVALID] = angle_invalid;
            rd_d[`IAV_S_ROLLOVR] = roll_over;
            rd_d[`IAV_S_BUSY]    = (st_q != ST_IDLE);
            rd_d[`IAV_S_HAVE]    = have_q;
        end else if (paddr == `IAV_A_ANGLES) begin
            rd_d = {roll_out, pitch_out};
        end else if (paddr == `IAV_A_EULER) begin
            rd_d = {eul_r_q, eul_p_q};
        end else if (paddr == `IAV_A_GERR) begin
            rd_d[W-1:0] = gerr_q;
        end else if (paddr == `IAV_A_GANGLE) begin
            rd_d[15:0] = rho_q;
        end else if (paddr == `IAV_A_COUNT) begin
            rd_d[15:0] = count_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // write takes effect at the completing edge only
    assign wr_en = psel & penable & pready & pwrite & ~err_d;

    // ==========================================================
    // apb slave: one wait-free access phase, answer from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
            type_q   <= `IAV_CTRL_RST;
            frame_q  <= `IAV_FRAME_RST;
            maxerr_q <= `IAV_MAXERR_RST;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & err_d;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0;
            if (wr_en) begin
                if (paddr == `IAV_A_CTRL) begin
                    type_q <= pwdata[1:0];                       // RULE_14
                end else if (paddr == `IAV_A_FRAME) begin
                    frame_q <= pwdata[10:0];                     // RULE_06
                end else if (paddr == `IAV_A_MAXERR) begin
                    maxerr_q <= pwdata[W-1:0];                   // RULE_03
                end
            end
        end
    end
endmodule

// ---- verif/iav_top_assertions.sv ----
/* iav_top checker: apb answer, sample handshake, angle ranges.
   sees only top ports; bound at the foot. */
`timescale 1ns/10ps
module iav_top_assertions #(parameter W = 20) (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // samples
    input wire [15:0] accel_z,
    input wire        accel_valid,
    input wire        accel_ready,
    // results
    input wire [15:0] pitch_out,
    input wire [15:0] roll_out,
    input wire        angle_invalid,
    input wire        roll_over,
    input wire        result_valid
);
// ====
// shadow of type, frame and the z sample taken
reg        [1:0]  typ_q;   // selected angle type
reg               frm_q;   // frame left at identity
reg signed [15:0] az_q;    // z of the sample in flight
wire              wr_hit = psel && penable && pready && pwrite;
wire signed [15:0] p_s = pitch_out;
wire signed [15:0] r_s = roll_out;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        typ_q <= 2'h0;
        frm_q <= 1'b1;
        az_q  <= 16'h0000;
    end else begin
        if (wr_hit && paddr == 8'h00) typ_q <= pwdata[1:0];
        if (wr_hit && paddr == 8'h04) frm_q <= (pwdata[10:0] == 11'h210);
        if (accel_valid && accel_ready) az_q <= accel_z;
    end
end
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// ====
// assertions
a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a pulse");
a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
a_take_busy: assert property (accel_valid && accel_ready |=> !accel_ready)
    else $error("ready high after take");
a_answer_bound: assert property (accel_valid && accel_ready |-> ##[100:200] result_valid)
    else $error("no result in time");
a_ready_back: assert property (result_valid |-> accel_ready && !$past(accel_ready))
    else $error("ready not back");
a_result_hold: assert property (!result_valid |-> $stable({pitch_out, roll_out, angle_invalid, roll_over}))
    else $error("outputs moved");
a_euler_pitch: assert property (result_valid && typ_q == 2'h3 |-> p_s >= -16'sh2d00 && p_s <= 16'sh2d00)
    else $error("euler pitch beyond ninety");
a_narrow_range: assert property (result_valid && typ_q == 2'h0 |->
    p_s >= -16'sh2d00 && p_s <= 16'sh2d00 && r_s >= -16'sh2d00 && r_s <= 16'sh2d00)
    else $error("narrow tilt beyond ninety");
a_roll_span: assert property (result_valid |-> r_s >= -16'sh5a00 && r_s <= 16'sh5a00)
    else $error("roll beyond one eighty");
a_rollover_sign: assert property (result_valid && frm_q && (az_q > 16'sh0400 || az_q < -16'sh0400)
    |-> roll_over == (az_q > 16'sh0000))
    else $error("roll-over flag wrong");
endmodule
bind iav_top iav_top_assertions #(.W(W)) chk_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accel_z(accel_z), .accel_valid(accel_valid),
    .accel_ready(accel_ready), .pitch_out(pitch_out), .roll_out(roll_out),
    .angle_invalid(angle_invalid), .roll_over(roll_over), .result_valid(result_valid));

// ---- verif/iav_accel_src.sv ----
/* accelerometer model: one three-axis sample per go, after a lag,
   held until taken. assumes go only when idle. */
`timescale 1ns/10ps
module iav_accel_src (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // bench request
    input wire        go,
    input wire [7:0]  lag,
    input wire [47:0] smp,
    output reg        busy,
    // sample port
    output reg [15:0] accel_x,
    output reg [15:0] accel_y,
    output reg [15:0] accel_z,
    output reg        accel_valid,
    input wire        accel_ready
);
reg [7:0]  cnt_q;  // cycles left before the offer
reg [47:0] smp_q;  // sample waiting to be offered
// ====
// released lines show the inverse, never stale data
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        busy        <= 1'b0;
        accel_valid <= 1'b0;
        cnt_q       <= 8'h00;
        smp_q       <= 48'h0;
        {accel_x, accel_y, accel_z} <= 48'h0;
    end else if (go && !busy) begin
        busy  <= 1'b1;
        cnt_q <= lag;
        smp_q <= smp;
    end else if (accel_valid && accel_ready) begin
        accel_valid <= 1'b0;
        busy        <= 1'b0;
        {accel_x, accel_y, accel_z} <= ~{accel_x, accel_y, accel_z};
    end else if (busy && !accel_valid) begin
        if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
        else accel_valid <= 1'b1;
        if (cnt_q == 8'h00) {accel_x, accel_y, accel_z} <= smp_q;
    end
end
endmodule

// ---- verif/tb.sv ----
/* bench for iav_top: apb registers, model samples, real-arithmetic
   angles. assumes the consts header. */
`timescale 1ns/10ps
`include "iav_consts.vh"
module tb;
// ====
// signals
reg         pclk, presetn, psel, penable, pwrite, go, re;
reg  [7:0]  paddr, lag;
reg  [31:0] pwdata, rq;  // rq: last read word
reg  [47:0] smp;
reg  [10:0] fr;          // frame in use
reg  [19:0] mx;          // max gravity error
wire [31:0] prdata;
wire [15:0] accel_x, accel_y, accel_z, pitch_out, roll_out;
wire        pready, pslverr, accel_valid, accel_ready, angle_invalid, roll_over, result_valid;
int         bad_count, tests_run, t;
iav_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .accel_valid(accel_valid),
    .accel_ready(accel_ready), .pitch_out(pitch_out), .roll_out(roll_out),
    .angle_invalid(angle_invalid), .roll_over(roll_over), .result_valid(result_valid));
iav_accel_src src_u (.pclk(pclk), .presetn(presetn), .go(go), .lag(lag), .smp(smp), .busy(),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .accel_valid(accel_valid),
    .accel_ready(accel_ready));
initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
end
// ====
// report and compare
task tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
task hang;
    bad_count++;
    tally_and_finish;
endtask
task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
        bad_count++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// angles modulo a full turn, within cordic error
task chk_ang(input [15:0] got, input [15:0] exp);
    int d;
    d = $signed(got) - $signed(exp);
    if (d > 23040) d -= 46080;
    if (d < -23040) d += 46080;
    if (^got === 1'bx || d > 13 || d < -13) chk(got, exp);
    else tests_run++;
endtask
// ====
// apb master: waits on pready, bounded
task apb(input bit wr, input [7:0] a, input [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 16) hang;
    rq = prdata;
    re = pslverr;
    {psel, penable} <= 2'b00;
endtask
// ====
// expected angles in 1/128 degree, {roll, pitch}
function automatic [15:0] ang(input real y, input real x);
    return int'($atan2(y, x) * 180.0 / 3.14159265358979 * 128.0);
endfunction
function automatic [31:0] exp_ang(input [1:0] ty, input real gx, input real gy, input real gz);
    real dp, dr;
    dp = (ty == 2'h2) ? gz : $sqrt(gy * gy + gz * gz);
    dr = ty[1] ? gz : $sqrt(gx * gx + gz * gz);
    if (ty == 2'h1 && gz < 0.0) begin
        dp = -dp;
        dr = -dr;
    end
    return {ang(gy, dr), ang(-gx, dp)};
endfunction
// one sample through the model, all results but the gravity angle checked
task run_smp(input [1:0] ty, input bit rnd, input [47:0] fix);
    reg signed [15:0] a [3];
    real g [3], er;
    reg [31:0] e;
    int i, k, n;
    for (i = 0; i < 3; i++) begin
        k = $urandom_range(32'h5000, 32'h0200);
        a[i] = rnd ? (($urandom % 2) ? -k : k) : fix[47-16*i -: 16];
    end
    for (i = 0; i < 3; i++) begin
        k = fr[4*i +: 2];
        g[i] = fr[4*i+2] ? a[k] : -a[k];
    end
    @(posedge pclk);
    smp <= {a[0], a[1], a[2]};
    lag <= $urandom_range(3, 0);
    go  <= 1'b1;
    @(posedge pclk);
    go  <= 1'b0;
    for (n = 0; n < 400 && result_valid !== 1'b1; n++) @(negedge pclk);
    if (n == 400) hang;
    e = exp_ang(ty, g[0], g[1], g[2]);
    chk_ang(pitch_out, e[15:0]);
    chk_ang(roll_out, e[31:16]);
    er = $sqrt(g[0] * g[0] + g[1] * g[1] + g[2] * g[2]) - 16384.0;
    if (er < 0.0) er = -er;
    if (er > mx + 8.0 || er < mx - 8.0) chk(angle_invalid, er > mx);
    chk(roll_over, g[2] < 0.0);
    e = exp_ang(2'h3, g[0], g[1], g[2]);
    apb(1'b0, `IAV_A_EULER, 32'h0);
    chk_ang(rq[15:0], e[15:0]);
    chk_ang(rq[31:16], e[31:16]);
    apb(1'b0, `IAV_A_GERR, 32'h0);
    chk_ang(rq[15:0], int'(er));
endtask
// ====
// main sequence
initial begin
    {presetn, psel, penable, pwrite, go, re} = 6'h00;
    {paddr, lag, pwdata, rq, smp} = 128'h0;
    {bad_count, tests_run} = 0;
    fr = 11'h210;
    mx = 20'h00800;
    void'($urandom(76));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `IAV_A_CTRL, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, `IAV_A_FRAME, 32'h0);
    chk(rq, 32'h210);
    apb(1'b0, `IAV_A_MAXERR, 32'h0);
    chk(rq, 32'h800);
    apb(1'b0, 8'h24, 32'h0);
    chk(re, 1'b1);
    chk(rq, 32'h0);
    apb(1'b1, `IAV_A_STATUS, 32'hf);
    apb(1'b0, `IAV_A_STATUS, 32'h0);
    chk(rq, 32'h0);
    for (t = 0; t < 8; t++) begin
        mx = $urandom_range(32'h3000, 32'h0100);
        fr = t[2] ? 11'h412 : 11'h210;
        apb(1'b1, `IAV_A_CTRL, t[1:0]);
        apb(1'b1, `IAV_A_FRAME, fr);
        apb(1'b1, `IAV_A_MAXERR, mx);
        repeat (6) run_smp(t[1:0], 1'b1, 48'h0);
    end
    fr = 11'h210;
    apb(1'b1, `IAV_A_FRAME, fr);
    for (t = 0; t < 2; t++) begin
        mx = t ? 20'h00110 : 20'h000f0;
        apb(1'b1, `IAV_A_MAXERR, mx);
        run_smp(2'h3, 1'b0, 48'h0000_0000_bf00);
    end
    apb(1'b0, `IAV_A_COUNT, 32'h0);
    chk(rq, 32'h32);
    tally_and_finish;
end
endmodule
